// [rtl/lhi_pkg.sv]
// Package for the link host interrupt unit: offsets, fields, types
package lhi_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  localparam logic [11:0] OFS_EVT_SET  = 12'h080;
  localparam logic [11:0] OFS_EVT_CLR  = 12'h084;
  localparam logic [11:0] OFS_MSK_SET  = 12'h088;
  localparam logic [11:0] OFS_MSK_CLR  = 12'h08C;
  localparam logic [11:0] OFS_ITE_SET  = 12'h090;
  localparam logic [11:0] OFS_ITE_CLR  = 12'h094;
  localparam logic [11:0] OFS_ITM_SET  = 12'h098;
  localparam logic [11:0] OFS_ITM_CLR  = 12'h09C;
  localparam logic [11:0] OFS_IRE_SET  = 12'h0A0;
  localparam logic [11:0] OFS_IRE_CLR  = 12'h0A4;
  localparam logic [11:0] OFS_IRM_SET  = 12'h0A8;
  localparam logic [11:0] OFS_IRM_CLR  = 12'h0AC;
  localparam logic [11:0] OFS_LNK_SET  = 12'h0E0;
  localparam logic [11:0] OFS_LNK_CLR  = 12'h0E4;

  localparam int unsigned BIT_ATX_REQ   = 0;
  localparam int unsigned BIT_ATX_RSP   = 1;
  localparam int unsigned BIT_ARX_REQ   = 2;
  localparam int unsigned BIT_ARX_RSP   = 3;
  localparam int unsigned BIT_RQ_PKT    = 4;
  localparam int unsigned BIT_RS_PKT    = 5;
  localparam int unsigned BIT_ISO_TX    = 6;
  localparam int unsigned BIT_ISO_RX    = 7;
  localparam int unsigned BIT_PW_ERR    = 8;
  localparam int unsigned BIT_LOCK_ERR  = 9;
  localparam int unsigned BIT_SELFID    = 16;
  localparam int unsigned BIT_BUS_RST   = 17;
  localparam int unsigned BIT_UNRECOV   = 24;
  localparam int unsigned BIT_CYC_LONG  = 25;
  localparam int unsigned BIT_MASTER_EN = 31;
  localparam int unsigned BIT_CYC_MSTR  = 21;
  localparam int unsigned BIT_CYC_TMR   = 20;

  localparam logic [31:0] EVT_VALID  = 32'h0303_03FF;
  localparam logic [31:0] MSK_VALID  = 32'h87FF_FFFF;
  localparam logic [31:0] LNK_VALID  = 32'h0030_0600;
  localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
  localparam logic [3:0]  ISO_ZERO   = 4'h0;

  localparam int unsigned ISO_CTX     = 4;
  localparam int unsigned CYC_LONG_US = 115;
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned CYC_LONG_CYCLES = CYC_LONG_US * CLK_MHZ + 1;

  // Hardware event pulses from the DMA and link paths
  typedef struct packed {
    logic       atx_req_done;
    logic       atx_rsp_done;
    logic       arx_req_done;
    logic       arx_rsp_done;
    logic       rq_pkt_stored;
    logic       rs_pkt_stored;
    logic       pw_err;
    logic       lock_err;
    logic       selfid_done;
    logic       bus_reset;
    logic       unrecov;
    logic [3:0] iso_tx_done;
    logic [3:0] iso_rx_done;
  } lhi_event_t;

  // Register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } lhi_req_t;
endpackage : lhi_pkg

// [rtl/lhi_interrupt_unit.sv]
// Interrupt aggregation unit of the link host controller
//
// Contract
// R1 - Self-ID stream complete sets event 16
// R2 - Lock response without ack_complete sets 9
// R3 - Posted write host error sets 8
// R4 - Bit 7 is masked iso receive OR
// R5 - Bit 6 is masked iso transmit OR
// R6 - Response buffer packet sets event 5
// R7 - Request buffer packet sets event 4
// R8 - Receive descriptor completions set 3, 2
// R9 - Transmit command completions set 1, 0
// R10 - Zero mask blocks interrupt, event still kept
// R11 - Mask set/clear addresses, read returns mask
// R12 - Mask bit 31 is master enable
// R13 - Iso transmit done with always-interrupt sets bit
// R14 - Iso receive done with always-interrupt sets bit
// R15 - Iso event sets only when mask set
// R16 - Software clears iso events via clear address
// R17 - Iso mask bits enable context interrupts
// R18 - Cycle too long clears cycle master, blocks set
// R19 - Cycle over 115 us sets event 25
// R20 - Halting error sets event 24
// R21 - PHY bus reset sets event 17
// R22 - Interrupt when enabled and masked event pending
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module lhi_interrupt_unit
  import lhi_pkg::*;
#(
  parameter int unsigned CYC_LONG_CNT = lhi_pkg::CYC_LONG_CYCLES
) (
  input  wire logic              CORE_CLK,
  input  wire logic              SYS_RST,
  input  wire logic              SOFT_RST,
  input  wire lhi_pkg::lhi_req_t REG_REQ,
  output logic [31:0]            REG_RDATA,
  input  wire lhi_pkg::lhi_event_t EVENTS,
  input  wire logic              CYC_START_TX,
  input  wire logic              SUBACTION_GAP,
  output logic                   CYCLE_MASTER,
  output logic                   CYCLE_TIMER_EN,
  output logic                   HOST_IRQ
);
  import lhi_pkg::*;

  typedef enum logic [1:0] {
    CT_IDLE = 2'b01,
    CT_RUN  = 2'b10
  } lhi_ct_state_t;

  logic [31:0]   evt_reg;
  logic [31:0]   msk_reg;
  logic [3:0]    ite_reg;
  logic [3:0]    itm_reg;
  logic [3:0]    ire_reg;
  logic [3:0]    irm_reg;
  logic [31:0]   lnk_reg;
  logic [31:0]   rdata_reg;
  logic [31:0]   rdata_next;
  logic [31:0]   evt_set;
  logic [31:0]   evt_next;
  logic [31:0]   lnk_next;
  logic          iso_tx_any;
  logic          iso_rx_any;
  logic          cyc_long;
  logic          rst;
  logic [15:0]   ct_cnt_reg;
  lhi_ct_state_t ct_state_reg;

  assign rst = SYS_RST | SOFT_RST;

  function automatic logic hit(input logic [11:0] ofs);
    hit = REG_REQ.wr && (REG_REQ.addr == ofs);
  endfunction : hit

  // Cycle length watchdog from cycle start to subaction gap
  always_ff @(posedge CORE_CLK) begin
    if (rst) begin
      ct_state_reg <= CT_IDLE;
      ct_cnt_reg   <= 16'h0000;
    end else begin
      unique case (ct_state_reg)
        CT_IDLE: begin
          if (CYC_START_TX) begin
            ct_state_reg <= CT_RUN;
            ct_cnt_reg   <= 16'h0000;
          end
        end
        CT_RUN: begin
          if (SUBACTION_GAP || cyc_long) begin
            ct_state_reg <= CT_IDLE;
          end else begin
            ct_cnt_reg <= ct_cnt_reg + 16'h0001;
          end
        end
      endcase
    end
  end
  // Fires exactly one cycle past 115 us, well under 120 us
  assign cyc_long = (ct_state_reg == CT_RUN) && !SUBACTION_GAP
                    && (ct_cnt_reg == 16'(CYC_LONG_CNT - 1)); // [R19]

  // A gap in the same cycle as the limit still counts as in time
  chk_ct_gap: assert property (@(posedge CORE_CLK) disable iff (rst) // [R19]
    SUBACTION_GAP |-> !cyc_long)
    else $error("Cycle too long despite gap");
  chk_ct_restart: assert property (@(posedge CORE_CLK) disable iff (rst) // [R19]
    (ct_state_reg == CT_IDLE) && CYC_START_TX |=> (ct_state_reg == CT_RUN) && (ct_cnt_reg == 16'h0000))
    else $error("Cycle watchdog did not start");
  chk_ct_count: assert property (@(posedge CORE_CLK) disable iff (rst) // [R19]
    (ct_state_reg == CT_RUN) && !SUBACTION_GAP && !cyc_long |=> ct_cnt_reg == $past(ct_cnt_reg) + 16'h0001)
    else $error("Cycle watchdog count skipped");
  chk_cyc_long_evt: assert property (@(posedge CORE_CLK) disable iff (rst) // [R19]
    cyc_long |=> evt_reg[BIT_CYC_LONG])
    else $error("Cycle too long event not recorded");

  assign iso_tx_any = |(ite_reg & itm_reg); // [R5] [R17]
  assign iso_rx_any = |(ire_reg & irm_reg); // [R4] [R17]

  always_comb begin
    evt_set = ZERO_WORD;
    evt_set[BIT_SELFID]   = EVENTS.selfid_done;   // [R1]
    evt_set[BIT_LOCK_ERR] = EVENTS.lock_err;      // [R2]
    evt_set[BIT_PW_ERR]   = EVENTS.pw_err;        // [R3]
    evt_set[BIT_RS_PKT]   = EVENTS.rs_pkt_stored; // [R6]
    evt_set[BIT_RQ_PKT]   = EVENTS.rq_pkt_stored; // [R7]
    evt_set[BIT_ARX_RSP]  = EVENTS.arx_rsp_done;  // [R8]
    evt_set[BIT_ARX_REQ]  = EVENTS.arx_req_done;  // [R8]
    evt_set[BIT_ATX_RSP]  = EVENTS.atx_rsp_done;  // [R9]
    evt_set[BIT_ATX_REQ]  = EVENTS.atx_req_done;  // [R9]
    evt_set[BIT_CYC_LONG] = cyc_long;             // [R19]
    evt_set[BIT_UNRECOV]  = EVENTS.unrecov;       // [R20]
    evt_set[BIT_BUS_RST]  = EVENTS.bus_reset;     // [R21]
  end

  // Hardware set wins over a same-cycle clear, clear wins over a software set; bits 7 and 6 mirror the iso groups
  always_comb begin
    evt_next = evt_reg;
    if (hit(OFS_EVT_SET)) begin
      evt_next = evt_next | REG_REQ.wdata;
    end
    if (hit(OFS_EVT_CLR)) begin
      evt_next = evt_next & ~REG_REQ.wdata;
    end
    evt_next = (evt_next | evt_set) & EVT_VALID;
    evt_next[BIT_ISO_TX] = iso_tx_any; // [R5]
    evt_next[BIT_ISO_RX] = iso_rx_any; // [R4]
  end

  always_ff @(posedge CORE_CLK) begin
    if (rst) begin
      evt_reg <= ZERO_WORD;
    end else begin
      evt_reg <= evt_next; // [R10]
    end
  end

  chk_pw_set: assert property (@(posedge CORE_CLK) disable iff (rst) // [R3]
    EVENTS.pw_err |=> evt_reg[BIT_PW_ERR])
    else $error("Posted write error not recorded");
  chk_rs_pkt_set: assert property (@(posedge CORE_CLK) disable iff (rst) // [R6]
    EVENTS.rs_pkt_stored |=> evt_reg[BIT_RS_PKT])
    else $error("Response packet event not recorded");
  chk_rq_pkt_set: assert property (@(posedge CORE_CLK) disable iff (rst) // [R7]
    EVENTS.rq_pkt_stored |=> evt_reg[BIT_RQ_PKT])
    else $error("Request packet event not recorded");
  chk_arx_rsp_set: assert property (@(posedge CORE_CLK) disable iff (rst) // [R8]
    EVENTS.arx_rsp_done |=> evt_reg[BIT_ARX_RSP])
    else $error("Receive response done not recorded");
  chk_arx_req_set: assert property (@(posedge CORE_CLK) disable iff (rst) // [R8]
    EVENTS.arx_req_done |=> evt_reg[BIT_ARX_REQ])
    else $error("Receive request done not recorded");
  chk_atx_rsp_set: assert property (@(posedge CORE_CLK) disable iff (rst) // [R9]
    EVENTS.atx_rsp_done |=> evt_reg[BIT_ATX_RSP])
    else $error("Transmit response done not recorded");
  chk_atx_req_set: assert property (@(posedge CORE_CLK) disable iff (rst) // [R9]
    EVENTS.atx_req_done |=> evt_reg[BIT_ATX_REQ])
    else $error("Transmit request done not recorded");
  chk_unrecov_set: assert property (@(posedge CORE_CLK) disable iff (rst) // [R20]
    EVENTS.unrecov |=> evt_reg[BIT_UNRECOV])
    else $error("Halting error not recorded");
  chk_bus_rst_set: assert property (@(posedge CORE_CLK) disable iff (rst) // [R21]
    EVENTS.bus_reset |=> evt_reg[BIT_BUS_RST])
    else $error("Bus reset event not recorded");
  chk_evt_sticky: assert property (@(posedge CORE_CLK) disable iff (rst) // [R10]
    evt_reg[BIT_SELFID] && !hit(OFS_EVT_CLR) |=> evt_reg[BIT_SELFID])
    else $error("Event bit lost without clear");
  chk_iso_rx_sum: assert property (@(posedge CORE_CLK) disable iff (rst) // [R4]
    ##1 evt_reg[BIT_ISO_RX] == $past(iso_rx_any))
    else $error("Iso receive summary wrong");

  always_ff @(posedge CORE_CLK) begin
    if (rst) begin
      msk_reg <= ZERO_WORD; // [R12]
    end else if (hit(OFS_MSK_SET)) begin
      msk_reg <= (msk_reg | REG_REQ.wdata) & MSK_VALID; // [R11]
    end else if (hit(OFS_MSK_CLR)) begin
      msk_reg <= msk_reg & ~REG_REQ.wdata; // [R11]
    end
  end

  chk_mask_clear: assert property (@(posedge CORE_CLK) disable iff (rst) // [R11]
    hit(OFS_MSK_CLR) |=> (msk_reg & $past(REG_REQ.wdata)) == ZERO_WORD)
    else $error("Mask clear write lost");

  always_ff @(posedge CORE_CLK) begin
    if (rst) begin
      itm_reg <= ISO_ZERO;
      irm_reg <= ISO_ZERO;
    end else begin
      if (hit(OFS_ITM_SET)) begin
        itm_reg <= itm_reg | REG_REQ.wdata[ISO_CTX-1:0];
      end else if (hit(OFS_ITM_CLR)) begin
        itm_reg <= itm_reg & ~REG_REQ.wdata[ISO_CTX-1:0];
      end
      if (hit(OFS_IRM_SET)) begin
        irm_reg <= irm_reg | REG_REQ.wdata[ISO_CTX-1:0];
      end else if (hit(OFS_IRM_CLR)) begin
        irm_reg <= irm_reg & ~REG_REQ.wdata[ISO_CTX-1:0];
      end
    end
  end

  // Iso event bits: sets gated by the mask, set wins over clear
  always_ff @(posedge CORE_CLK) begin
    if (rst) begin
      ite_reg <= ISO_ZERO;
      ire_reg <= ISO_ZERO;
    end else begin
      ite_reg <= ((hit(OFS_ITE_CLR) ? ite_reg & ~REG_REQ.wdata[ISO_CTX-1:0] : ite_reg)
                 | ((EVENTS.iso_tx_done
                   | (hit(OFS_ITE_SET) ? REG_REQ.wdata[ISO_CTX-1:0] : ISO_ZERO))
                   & itm_reg)); // [R13] [R15] [R16]
      ire_reg <= ((hit(OFS_IRE_CLR) ? ire_reg & ~REG_REQ.wdata[ISO_CTX-1:0] : ire_reg)
                 | ((EVENTS.iso_rx_done
                   | (hit(OFS_IRE_SET) ? REG_REQ.wdata[ISO_CTX-1:0] : ISO_ZERO))
                   & irm_reg)); // [R14] [R15] [R16]
    end
  end

  // Iso masks and events checked per context bit
  chk_itm_set: assert property (@(posedge CORE_CLK) disable iff (rst) // [R17]
    hit(OFS_ITM_SET) |=> (itm_reg & $past(REG_REQ.wdata[ISO_CTX-1:0]))
                         == $past(REG_REQ.wdata[ISO_CTX-1:0]))
    else $error("Iso transmit mask set lost");
  chk_itm_clear: assert property (@(posedge CORE_CLK) disable iff (rst) // [R17]
    hit(OFS_ITM_CLR) |=> (itm_reg & $past(REG_REQ.wdata[ISO_CTX-1:0])) == ISO_ZERO)
    else $error("Iso transmit mask clear lost");
  chk_irm_set: assert property (@(posedge CORE_CLK) disable iff (rst) // [R17]
    hit(OFS_IRM_SET) |=> (irm_reg & $past(REG_REQ.wdata[ISO_CTX-1:0]))
                         == $past(REG_REQ.wdata[ISO_CTX-1:0]))
    else $error("Iso receive mask set lost");
  chk_irm_clear: assert property (@(posedge CORE_CLK) disable iff (rst) // [R17]
    hit(OFS_IRM_CLR) |=> (irm_reg & $past(REG_REQ.wdata[ISO_CTX-1:0])) == ISO_ZERO)
    else $error("Iso receive mask clear lost");
  chk_ite_hw_set: assert property (@(posedge CORE_CLK) disable iff (rst) // [R13]
    ##1 (ite_reg & $past(EVENTS.iso_tx_done & itm_reg)) == $past(EVENTS.iso_tx_done & itm_reg))
    else $error("Iso transmit completion lost");
  chk_ire_hw_set: assert property (@(posedge CORE_CLK) disable iff (rst) // [R14]
    ##1 (ire_reg & $past(EVENTS.iso_rx_done & irm_reg)) == $past(EVENTS.iso_rx_done & irm_reg))
    else $error("Iso receive completion lost");
  chk_ite_clear: assert property (@(posedge CORE_CLK) disable iff (rst) // [R16]
    hit(OFS_ITE_CLR) |=>
      (ite_reg & $past(REG_REQ.wdata[ISO_CTX-1:0] & ~EVENTS.iso_tx_done)) == ISO_ZERO)
    else $error("Iso transmit event clear lost");
  chk_ire_clear: assert property (@(posedge CORE_CLK) disable iff (rst) // [R16]
    hit(OFS_IRE_CLR) |=>
      (ire_reg & $past(REG_REQ.wdata[ISO_CTX-1:0] & ~EVENTS.iso_rx_done)) == ISO_ZERO)
    else $error("Iso receive event clear lost");
  chk_iso_tx_gate: assert property (@(posedge CORE_CLK) disable iff (rst) // [R15]
    (ite_reg & ~$past(ite_reg) & ~$past(itm_reg)) == ISO_ZERO)
    else $error("Iso transmit bit set while masked");

  // Cycle master cannot be set while the too-long event stands
  always_comb begin
    lnk_next = lnk_reg;
    if (hit(OFS_LNK_SET)) begin
      lnk_next = lnk_next | (REG_REQ.wdata & LNK_VALID);
    end
    if (hit(OFS_LNK_CLR)) begin
      lnk_next = lnk_next & ~REG_REQ.wdata;
    end
    if (evt_reg[BIT_CYC_LONG] || cyc_long) begin
      lnk_next[BIT_CYC_MSTR] = 1'b0; // [R18]
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (rst) begin
      lnk_reg <= ZERO_WORD;
    end else begin
      lnk_reg <= lnk_next;
    end
  end

  // Software set cannot win while the too-long event stands
  chk_cycmstr_block: assert property (@(posedge CORE_CLK) disable iff (rst) // [R18]
    evt_reg[BIT_CYC_LONG] |=> !CYCLE_MASTER)
    else $error("Cycle master set while event stands");
  chk_lnk_clear: assert property (@(posedge CORE_CLK) disable iff (rst) // [R18]
    hit(OFS_LNK_CLR) |=> (lnk_reg & $past(REG_REQ.wdata)) == ZERO_WORD)
    else $error("Link control clear lost");

  always_comb begin
    rdata_next = ZERO_WORD;
    if (REG_REQ.rd) begin
      unique case (REG_REQ.addr)
        OFS_EVT_SET, OFS_EVT_CLR: rdata_next = evt_reg;
        OFS_MSK_SET, OFS_MSK_CLR: rdata_next = msk_reg; // [R11]
        OFS_ITE_SET, OFS_ITE_CLR: rdata_next = {28'h000_0000, ite_reg};
        OFS_ITM_SET, OFS_ITM_CLR: rdata_next = {28'h000_0000, itm_reg};
        OFS_IRE_SET, OFS_IRE_CLR: rdata_next = {28'h000_0000, ire_reg};
        OFS_IRM_SET, OFS_IRM_CLR: rdata_next = {28'h000_0000, irm_reg};
        OFS_LNK_SET, OFS_LNK_CLR: rdata_next = lnk_reg;
        default:                  rdata_next = ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (rst) begin
      rdata_reg <= ZERO_WORD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  chk_rdata_idle: assert property (@(posedge CORE_CLK) disable iff (rst) // [R11]
    !REG_REQ.rd |=> REG_RDATA == ZERO_WORD)
    else $error("Read data outside read slot");
  chk_rdata_mask: assert property (@(posedge CORE_CLK) disable iff (rst) // [R11]
    REG_REQ.rd && (REG_REQ.addr == OFS_MSK_CLR) |=> REG_RDATA == $past(msk_reg))
    else $error("Mask read returned wrong value");
  chk_rdata_iso: assert property (@(posedge CORE_CLK) disable iff (rst) // [R17]
    REG_REQ.rd && (REG_REQ.addr == OFS_ITM_SET) |=> REG_RDATA == {28'h000_0000, $past(itm_reg)})
    else $error("Iso mask read returned wrong value");

  // Registered so a glitch on the event inputs never reaches the CPU
  logic irq_reg;
  always_ff @(posedge CORE_CLK) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= msk_reg[BIT_MASTER_EN] && |(evt_reg & msk_reg & EVT_VALID); // [R22] [R10] [R12]
    end
  end

  assign REG_RDATA      = rdata_reg;
  assign HOST_IRQ       = irq_reg;
  assign CYCLE_MASTER   = lnk_reg[BIT_CYC_MSTR];
  assign CYCLE_TIMER_EN = lnk_reg[BIT_CYC_TMR];

  chk_master_gate: assert property (@(posedge CORE_CLK) disable iff (rst) // [R12]
    !msk_reg[BIT_MASTER_EN] |=> !HOST_IRQ)
    else $error("Interrupt raised with master enable off");
  chk_irq_cause: assert property (@(posedge CORE_CLK) disable iff (rst) // [R22]
    HOST_IRQ |-> $past(|(evt_reg & msk_reg & EVT_VALID)))
    else $error("Interrupt without masked event");
  chk_selfid_set: assert property (@(posedge CORE_CLK) disable iff (rst) // [R1]
    EVENTS.selfid_done |=> evt_reg[BIT_SELFID])
    else $error("Self-ID event not recorded");
  chk_lock_set: assert property (@(posedge CORE_CLK) disable iff (rst) // [R2]
    EVENTS.lock_err |=> evt_reg[BIT_LOCK_ERR])
    else $error("Lock error not recorded");
  chk_iso_tx_sum: assert property (@(posedge CORE_CLK) disable iff (rst) // [R5]
    ##1 evt_reg[BIT_ISO_TX] == $past(iso_tx_any))
    else $error("Iso transmit summary wrong");
  chk_iso_rx_gate: assert property (@(posedge CORE_CLK) disable iff (rst) // [R15]
    (ire_reg & ~$past(ire_reg) & ~$past(irm_reg)) == ISO_ZERO)
    else $error("Iso receive bit set while masked");
  chk_cycmstr_drop: assert property (@(posedge CORE_CLK) disable iff (rst) // [R18]
    cyc_long |=> !CYCLE_MASTER [*2])
    else $error("Cycle master not cleared");
  chk_cyc_long_time: assert property (@(posedge CORE_CLK) disable iff (rst) // [R19]
    cyc_long |-> ct_cnt_reg == 16'(CYC_LONG_CNT - 1))
    else $error("Cycle too long at wrong time");
  chk_mask_write: assert property (@(posedge CORE_CLK) disable iff (rst) // [R11]
    hit(OFS_MSK_SET) |=> (msk_reg & ($past(REG_REQ.wdata) & MSK_VALID))
                         == ($past(REG_REQ.wdata) & MSK_VALID))
    else $error("Mask set write lost");
  chk_irq_rise: assert property (@(posedge CORE_CLK) disable iff (rst) // [R22]
    msk_reg[BIT_MASTER_EN] && |(evt_reg & msk_reg & EVT_VALID) |=> HOST_IRQ)
    else $error("Enabled masked event gave no interrupt");
  chk_irq_fall: assert property (@(posedge CORE_CLK) disable iff (rst) // [R10]
    !(|(evt_reg & msk_reg & EVT_VALID)) |=> !HOST_IRQ)
    else $error("Interrupt held with no masked event");
endmodule : lhi_interrupt_unit

// [tb/lhi_host_model.sv]
// Host software model: register bus master of the interrupt unit
`timescale 1ns/1ps
module lhi_host_model
  import lhi_pkg::*;
(
  input  wire logic         clk,
  output lhi_pkg::lhi_req_t req,
  input  wire logic [31:0]  rdata
);
  initial begin
    req = '0;
  end

  // One-cycle write strobe, held until the taking edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= {a, d, 1'b1, 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    req <= {a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  // Events go away only by ones at the clear address
  task automatic clr(input logic [11:0] a, input logic [31:0] d);
    wr(a, d);
  endtask : clr
endmodule : lhi_host_model

// [tb/lhi_interrupt_unit_tb.sv]
// Self-checking bench of the link host interrupt unit
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module lhi_interrupt_unit_tb;
  import lhi_pkg::*;
  localparam int unsigned CYC = 20;
  logic                clk;
  logic                rst;
  logic                soft_rst;
  logic                cyc_start;
  logic                gap;
  lhi_req_t            req;
  logic [31:0]         rdata;
  lhi_event_t          events;
  logic                cyc_master;
  logic                timer_en;
  logic                irq;
  int                  num_errors;
  int                  total_checks;
  int                  cycles;

  lhi_interrupt_unit #(.CYC_LONG_CNT(CYC)) lhi_interrupt_unit_inst (
    .CORE_CLK(clk), .SYS_RST(rst), .SOFT_RST(soft_rst), .REG_REQ(req), .REG_RDATA(rdata),
    .EVENTS(events), .CYC_START_TX(cyc_start), .SUBACTION_GAP(gap),
    .CYCLE_MASTER(cyc_master), .CYCLE_TIMER_EN(timer_en), .HOST_IRQ(irq));
  lhi_host_model lhi_host_model_inst (.clk(clk), .req(req), .rdata(rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic results;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end

  task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    lhi_host_model_inst.rd(a, d);
    `CHK(d, e)
  endtask : chk_rd

  task automatic pulse(input logic [18:0] v);
    @(posedge clk);
    events <= v;
    @(posedge clk);
    events <= '0;
  endtask : pulse

  // Irq trails its cause by two cycles
  task automatic chk_irq(input logic e);
    repeat (3) @(posedge clk);
    #1;
    `CHK(irq, e)
  endtask : chk_irq

  task automatic t_regs;
    chk_rd(OFS_MSK_SET, 32'h0000_0000);
    chk_rd(12'h004, 32'h0000_0000);
    lhi_host_model_inst.wr(OFS_MSK_SET, 32'h8000_0201);
    chk_rd(OFS_MSK_CLR, 32'h8000_0201);
    lhi_host_model_inst.wr(OFS_MSK_CLR, 32'h0000_0200);
    chk_rd(OFS_MSK_SET, 32'h8000_0001);
    lhi_host_model_inst.wr(OFS_MSK_CLR, 32'hFFFF_FFFF);
    $display("test regs done");
  endtask : t_regs

  task automatic t_events;
    int pos[11] = '{0, 1, 2, 3, 4, 5, 8, 9, 16, 17, 24};
    for (int i = 0; i < 11; i++) begin
      pulse(19'h0_0001 << (18 - i));
      chk_rd(OFS_EVT_CLR, 32'h0000_0001 << pos[i]);
      lhi_host_model_inst.clr(OFS_EVT_CLR, 32'hFFFF_FFFF);
    end
    $display("test events done");
  endtask : t_events

  task automatic t_irq;
    lhi_host_model_inst.wr(OFS_MSK_SET, 32'h0001_0000);
    pulse(19'h0_0400);
    chk_irq(1'b0);
    lhi_host_model_inst.wr(OFS_MSK_SET, 32'h8000_0000);
    chk_irq(1'b1);
    lhi_host_model_inst.wr(OFS_MSK_CLR, 32'h0001_0000);
    chk_irq(1'b0);
    chk_rd(OFS_EVT_SET, 32'h0001_0000);
    lhi_host_model_inst.clr(OFS_EVT_CLR, 32'h0001_0000);
    $display("test irq done");
  endtask : t_irq

  task automatic t_iso;
    pulse(19'h0_0040);
    chk_rd(OFS_ITE_SET, 32'h0000_0000);
    lhi_host_model_inst.wr(OFS_ITM_SET, 32'h0000_0004);
    lhi_host_model_inst.wr(OFS_MSK_SET, 32'h8000_0040);
    pulse(19'h0_0040);
    chk_rd(OFS_ITE_CLR, 32'h0000_0004);
    chk_rd(OFS_EVT_SET, 32'h0000_0040);
    chk_irq(1'b1);
    lhi_host_model_inst.wr(OFS_IRM_SET, 32'h0000_0002);
    pulse(19'h0_0002);
    chk_rd(OFS_IRE_SET, 32'h0000_0002);
    chk_rd(OFS_EVT_SET, 32'h0000_00C0);
    lhi_host_model_inst.clr(OFS_ITE_CLR, 32'h0000_000F);
    lhi_host_model_inst.clr(OFS_IRE_CLR, 32'h0000_000F);
    chk_rd(OFS_EVT_SET, 32'h0000_0000);
    chk_irq(1'b0);
    lhi_host_model_inst.wr(OFS_MSK_CLR, 32'hFFFF_FFFF);
    $display("test iso done");
  endtask : t_iso

  task automatic cyc(input int gap_at);
    @(posedge clk);
    cyc_start <= 1'b1;
    @(posedge clk);
    cyc_start <= 1'b0;
    repeat (gap_at) @(posedge clk);
    gap <= 1'b1;
    @(posedge clk);
    gap <= 1'b0;
  endtask : cyc

  task automatic t_cycle;
    lhi_host_model_inst.wr(OFS_LNK_SET, 32'h0030_0000);
    chk_rd(OFS_LNK_CLR, 32'h0030_0000);
    `CHK(timer_en, 1'b1)
    cyc(CYC / 4);
    chk_rd(OFS_EVT_SET, 32'h0000_0000);
    `CHK(cyc_master, 1'b1)
    cyc(CYC + 10);
    chk_rd(OFS_EVT_SET, 32'h0200_0000);
    `CHK(cyc_master, 1'b0)
    lhi_host_model_inst.wr(OFS_LNK_SET, 32'h0020_0000);
    chk_rd(OFS_LNK_SET, 32'h0010_0000);
    lhi_host_model_inst.clr(OFS_EVT_CLR, 32'h0200_0000);
    lhi_host_model_inst.wr(OFS_LNK_SET, 32'h0020_0000);
    chk_rd(OFS_LNK_SET, 32'h0030_0000);
    $display("test cycle done");
  endtask : t_cycle

  task automatic t_soft;
    lhi_host_model_inst.wr(OFS_MSK_SET, 32'h8000_0001);
    chk_rd(OFS_ITM_SET, 32'h0000_0004);
    @(posedge clk);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    chk_rd(OFS_MSK_SET, 32'h0000_0000);
    chk_rd(OFS_LNK_SET, 32'h0000_0000);
    `CHK(timer_en, 1'b0)
    $display("test soft reset done");
  endtask : t_soft

  initial begin
    rst = 1'b1;
    soft_rst = 1'b0;
    cyc_start = 1'b0;
    gap = 1'b0;
    events = '0;
    num_errors = 0;
    total_checks = 0;
    cycles = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_events();
    t_irq();
    t_iso();
    t_cycle();
    t_soft();
    results();
  end
endmodule : lhi_interrupt_unit_tb
